/* logic/cpd_dispatch.v */
// Coprocessor dispatch channel and to-coprocessor data channel of the core.
// Assumes core-side requests are on clk_sys; busy and order-limit come from pins.
`timescale 1ns/1ps
`include "cpd_regs.vh"
module cpd_dispatch #(
  parameter WORD_W     = `CPD_WORD_W,
  parameter FIFO_DEPTH = `CPD_FIFO_DEPTH,
  parameter FIFO_AW    = 3
) (
  input  wire              clk_sys,                 // System clock, 20 MHz
  input  wire              rst_n,                   // Async reset, active low
  input  wire              exec_last,               // Last execute-stage cycle
  input  wire              pipe_stall,              // Integer pipeline stalled
  input  wire              cop_valid,               // Coprocessor instruction present
  input  wire [1:0]        cop_type,                // 0 arith, 1 to-cop, 2 from-cop
  input  wire [WORD_W-1:0] cop_instr,               // Instruction to dispatch
  input  wire              big_endian_mode,         // Core byte order
  output reg               dispatch_accept,         // Dispatched; high in strobe cycle
  input  wire              load_valid,              // Load data from memory
  output wire              load_ready,              // Load buffer has room
  input  wire [WORD_W-1:0] load_data,               // Load data word
  output reg               tocop_overrun,           // Data behind by three dispatches
  input  wire              arith_busy,              // Coprocessor arith busy pin
  input  wire              tocop_busy,              // Coprocessor to-cop busy pin
  input  wire              fromcop_busy,            // Coprocessor from-cop busy pin
  input  wire [2:0]        tocop_order_limit,       // Reorder limit, unused
  output reg  [WORD_W-1:0] instr_word,              // Instruction bus
  output reg               instr_latch_hint,        // Possible dispatch cycle
  output reg               compat32_mode,           // 32-bit compatibility
  output reg               big_endian_select,       // Byte order of dispatch
  output reg               arith_dispatch_strobe,   // Arith strobe
  output reg               tocop_dispatch_strobe,   // To-cop strobe
  output reg               fromcop_dispatch_strobe, // From-cop strobe
  output reg               nullify_strobe,          // Null transfer strobe
  output reg  [WORD_W-1:0] tocop_data,              // To-cop data word
  output reg               tocop_data_strobe,       // Data valid
  output reg  [2:0]        tocop_order_tag          // Order tag
);
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  reg  [1:0]        state;
  reg  [1:0]        next_state;
  reg  [1:0]        pend;
  reg  [1:0]        held_type;
  reg               pres_valid;
  reg  [1:0]        pres_type;
  wire              present;
  wire [2:0]        limit_s;
  wire [2:0]        busy_s;
  wire              busy_hit;
  wire              disp;
  wire              want;
  wire [1:0]        want_type;
  wire              fifo_valid;
  wire [WORD_W-1:0] fifo_data;
  wire              send;

  function [2:0] type_onehot;
    input [1:0] t;
    begin
      case (t)
        `CPD_TYPE_ARITH:   type_onehot = 3'b001;
        `CPD_TYPE_TOCOP:   type_onehot = 3'b010;
        `CPD_TYPE_FROMCOP: type_onehot = 3'b100;
        default:           type_onehot = 3'b000;
      endcase
    end
  endfunction

  // Busy must act in the dispatch cycle itself, so it is read raw, never synchronised
  assign busy_s = {fromcop_busy, tocop_busy, arith_busy};

  // Limit is ignored; kept synchronised only for a later reordering option
  cpd_sync #(.W(3)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (tocop_order_limit),
    .dout    (limit_s)
  );

  // Load data buffer; its ready stalls the memory side
  cpd_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (load_valid),
    .in_ready  (load_ready),
    .in_data   (load_data),
    .out_valid (fifo_valid),
    .out_ready (send),
    .out_data  (fifo_data)
  );

  assign want      = (state == ST_WAIT) | cop_valid;
  assign want_type = (state == ST_WAIT) ? held_type : cop_type;
  // Only the busy of the attempted type counts, sampled in the dispatch cycle
  assign busy_hit  = |(type_onehot(pres_type) & busy_s);
  // Present again after a busy refusal; never twice while the answer is unknown
  assign present   = want & exec_last & ~pipe_stall & (~pres_valid | busy_hit);
  // Pins show the word in the dispatch cycle; busy is judged in that same cycle
  assign disp      = pres_valid & ~busy_hit;
  // Data leaves only for an outstanding to_copro_op; never reordered
  assign send      = fifo_valid & (pend != 2'h0);

  always @*
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (cop_valid)
        begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (disp)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                   <= ST_IDLE;
      held_type               <= `CPD_TYPE_ARITH;
      pres_valid              <= 1'b0;
      pres_type               <= `CPD_TYPE_ARITH;
      dispatch_accept         <= 1'b0;
      pend                    <= 2'h0;
      instr_word              <= {WORD_W{1'b0}};
      instr_latch_hint        <= 1'b0;
      compat32_mode           <= `CPD_COMPAT32;
      big_endian_select       <= 1'b0;
      arith_dispatch_strobe   <= 1'b0;
      tocop_dispatch_strobe   <= 1'b0;
      fromcop_dispatch_strobe <= 1'b0;
      nullify_strobe          <= 1'b0;
      tocop_data              <= {WORD_W{1'b0}};
      tocop_data_strobe       <= 1'b0;
      tocop_order_tag         <= `CPD_TAG_IN_ORDER;
      tocop_overrun           <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == ST_IDLE && cop_valid)
      begin
        held_type  <= cop_type;
        instr_word <= cop_instr;
      end
      // Word and hint reach the pins one cycle before the registered strobe
      pres_valid        <= present;
      pres_type         <= want_type;
      instr_latch_hint  <= present;
      dispatch_accept   <= disp;
      compat32_mode     <= `CPD_COMPAT32;
      big_endian_select <= big_endian_mode;
      // Strobe one cycle after dispatch; late busy cannot retract it
      arith_dispatch_strobe   <= disp & (pres_type == `CPD_TYPE_ARITH);
      tocop_dispatch_strobe   <= disp & (pres_type == `CPD_TYPE_TOCOP);
      fromcop_dispatch_strobe <= disp & (pres_type == `CPD_TYPE_FROMCOP);
      nullify_strobe          <= disp;
      tocop_data              <= fifo_data;
      tocop_data_strobe       <= send;
      tocop_order_tag         <= `CPD_TAG_IN_ORDER;
      if (disp && pres_type == `CPD_TYPE_TOCOP && !send)
      begin
        pend <= pend + 2'h1;
      end
      else if (send && !(disp && pres_type == `CPD_TYPE_TOCOP))
      begin
        pend <= pend - 2'h1;
      end
      // Flag when a third to_copro_op is pending; core logic must prevent this
      tocop_overrun <= (pend == 2'h2) & disp & (pres_type == `CPD_TYPE_TOCOP)
                       & ~send;
    end
  end
endmodule

/* common/cpd_regs.vh */
// Width and field constants for the coprocessor dispatch and to-coprocessor data port.
// Included by the cpd_dispatch module only; definitions only.
`ifndef CPD_REGS_VH
`define CPD_REGS_VH

`define CPD_WORD_W       32
`define CPD_TAG_W        3
`define CPD_TAG_IN_ORDER 3'h0
`define CPD_COMPAT32     1'h1
`define CPD_MAX_PENDING  2
`define CPD_CNT_W        2
`define CPD_FIFO_DEPTH   8
`define CPD_TYPE_ARITH   2'h0
`define CPD_TYPE_TOCOP   2'h1
`define CPD_TYPE_FROMCOP 2'h2

`endif

/* logic/cpd_fifo.v */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module cpd_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk_sys,   // System clock
  input  wire             rst_n,     // Async reset, active low
  input  wire             in_valid,  // Write request
  output wire             in_ready,  // Space available
  input  wire [WIDTH-1:0] in_data,   // Write data
  output wire             out_valid, // Data available
  input  wire             out_ready, // Drain request
  output wire [WIDTH-1:0] out_data   // Head word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

/* logic/cpd_sync.v */
// Two-flop synchroniser for a bus of levels.
// Assumes the inputs come from another clock domain or a pin.
`timescale 1ns/1ps
module cpd_sync #(
  parameter W = 1
) (
  input  wire         clk_sys, // System clock
  input  wire         rst_n,   // Async reset, active low
  input  wire [W-1:0] din,     // Asynchronous levels
  output reg  [W-1:0] dout     // Synchronised levels
);
  reg [W-1:0] meta;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

/* verification/cpd_dispatch_asserts.sv */
// Checker for the dispatch port of cpd_dispatch.
// Bound to cpd_dispatch; sees its ports only.
`timescale 1ns/1ps
module cpd_dispatch_asserts (
  input wire       clk_sys,                 // clock
  input wire       rst_n,                   // reset
  input wire       exec_last,               // last execute
  input wire       pipe_stall,              // stall
  input wire       big_endian_mode,         // byte order in
  input wire       dispatch_accept,         // dispatch
  input wire       instr_latch_hint,        // hint
  input wire       compat32_mode,           // compat
  input wire [31:0] instr_word,             // instruction bus
  input wire       big_endian_select,       // byte order out
  input wire       arith_dispatch_strobe,   // arith
  input wire       tocop_dispatch_strobe,   // to-cop
  input wire       fromcop_dispatch_strobe, // from-cop
  input wire       nullify_strobe,          // null
  input wire [2:0] tocop_order_tag          // tag
);
  wire [2:0] stb = {arith_dispatch_strobe, tocop_dispatch_strobe, fromcop_dispatch_strobe};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  one_strobe_a: assert property ($onehot0(stb)) else $error("two strobes");
  null_or_a: assert property (nullify_strobe == |stb) else $error("null strobe");
  compat_high_a: assert property (compat32_mode) else $error("compat low");
  tag_zero_a: assert property (tocop_order_tag == 3'h0) else $error("tag");
  strobe_late_a: assert property (|stb |-> instr_word == $past(instr_word)) else $error("no word");
  strobe_cause_a: assert property (dispatch_accept == |stb) else $error("stray");
  last_nostall_a: assert property (instr_latch_hint |-> $past(exec_last) && !$past(pipe_stall))
    else $error("bad dispatch cycle");
  hint_high_a: assert property (|stb |-> $past(instr_latch_hint)) else $error("hint low");
  byte_order_a: assert property (instr_latch_hint |-> big_endian_select == $past(big_endian_mode))
    else $error("byte order");
endmodule

/* verification/cpd_copro_model.sv */
// Behavioural coprocessor on the far side of cpd_dispatch.
// Assumes the shared rising clk_sys and active-low rst_n.
`timescale 1ns/1ps
module cpd_copro_model (
  input  wire        clk_sys,               // clock
  input  wire        rst_n,                 // reset
  input  wire [31:0] instr_word,            // instruction
  input  wire        instr_latch_hint,      // hint
  input  wire        tocop_dispatch_strobe, // to-cop strobe
  input  wire [31:0] tocop_data,            // data
  input  wire        tocop_data_strobe,     // data valid
  input  wire        hold_arith,            // bench command
  input  wire        hold_fromcop,          // bench command
  output wire        arith_busy,            // busy pins
  output wire        tocop_busy,            // busy pins
  output wire        fromcop_busy,          // busy pins
  output wire [2:0]  tocop_order_limit,     // no reordering
  output reg  [31:0] cap_word,              // latched word
  output reg  [31:0] last_data,             // last word in
  output reg  [7:0]  rx_cnt                 // words in
);
  reg [1:0] pend;
  assign arith_busy = hold_arith;
  assign fromcop_busy = hold_fromcop;
  // Only two word buffers, so block further to-cop ops when full
  assign tocop_busy = pend >= 2'h2;
  assign tocop_order_limit = 3'h0;
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pend <= 2'h0;
      rx_cnt <= 8'h00;
      cap_word <= 32'h0000_0000;
      last_data <= 32'h0000_0000;
    end
    else
    begin
      if (instr_latch_hint)
        cap_word <= instr_word;
      pend <= pend + tocop_dispatch_strobe - tocop_data_strobe;
      if (tocop_data_strobe)
      begin
        last_data <= tocop_data;
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for cpd_dispatch with a coprocessor model.
// Stands alone; makes its own clock and reset.
`timescale 1ns/1ps
module tb;
  reg         clk_sys, rst_n, exec_last, pipe_stall, cop_valid, big_endian_mode;
  reg         load_valid, hold_arith, hold_fromcop;
  reg  [1:0]  cop_type;
  reg  [31:0] cop_instr, load_data;
  wire        dispatch_accept, load_ready, tocop_overrun, arith_busy, tocop_busy;
  wire        fromcop_busy, instr_latch_hint, compat32_mode, big_endian_select;
  wire        arith_dispatch_strobe, tocop_dispatch_strobe, fromcop_dispatch_strobe;
  wire        nullify_strobe, tocop_data_strobe;
  wire [2:0]  tocop_order_limit, tocop_order_tag;
  wire [31:0] instr_word, tocop_data, cap_word, last_data;
  wire [7:0]  rx_cnt;
  integer     n_mismatch, tests_run, i, k;
  cpd_dispatch u_cpd_dispatch (.*);
  cpd_copro_model u_cpd_copro_model (.*);
  task give_verdict;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Pulses the request for one cycle, then waits until taken or 8 cycles pass
  task issue(input [1:0] ty, input [31:0] ins, input exp_ok);
    reg ok;
    begin
      ok = 0;
      @(negedge clk_sys);
      cop_valid = 1;
      exec_last = 1;
      cop_type = ty;
      cop_instr = ins;
      big_endian_mode = ins[0];
      for (k = 0; k < 8 && !ok; k = k + 1)
      begin
        @(negedge clk_sys);
        cop_valid = 0;
        ok = dispatch_accept;
      end
      cmp(ok, exp_ok);
      if (ok)
      begin
        cmp({arith_dispatch_strobe, tocop_dispatch_strobe, fromcop_dispatch_strobe}, 3'h4 >> ty);
        cmp(instr_word, ins);
        cmp(big_endian_select, ins[0]);
      end
      exec_last = 0;
    end
  endtask
  task t_types;
    begin
      issue(2'h0, 32'h4a00_0011, 1);
      issue(2'h2, 32'h4800_0020, 1);
      issue(2'h0, 32'h4a00_0030, 1);
    end
  endtask
  task t_stall;
    begin
      pipe_stall = 1;
      issue(2'h0, 32'h4a00_0041, 0);
      pipe_stall = 0;
      issue(2'h0, 32'h4a00_0041, 1);
    end
  endtask
  task t_busy;
    begin
      hold_arith = 1;
      repeat (3) @(negedge clk_sys);
      issue(2'h0, 32'h4a00_0050, 0);
      hold_arith = 0;
      hold_fromcop = 1;
      issue(2'h0, 32'h4a00_0050, 1);
      hold_fromcop = 0;
    end
  endtask
  // Fill the buffer with no op pending, then let each op drain one word
  task t_fifo;
    begin
      for (i = 0; i < 9; i = i + 1)
      begin
        @(negedge clk_sys);
        load_valid = 1;
        load_data = 32'h5a5a_0000 + i;
        #20 cmp(load_ready, i < 8);
        @(negedge clk_sys);
        load_valid = 0;
      end
      for (i = 0; i < 8; i = i + 1)
      begin
        issue(2'h1, 32'h4880_0000 + i, 1);
        for (k = 0; k < 10 && rx_cnt != i + 1; k = k + 1)
          @(negedge clk_sys);
        cmp(rx_cnt, i + 1);
        cmp(last_data, 32'h5a5a_0000 + i);
      end
      cmp(load_ready, 1);
      cmp(tocop_overrun, 0);
    end
  endtask
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    {n_mismatch, tests_run, rst_n, exec_last, pipe_stall, cop_valid} = 0;
    {big_endian_mode, load_valid, hold_arith, hold_fromcop, cop_type} = 0;
    {cop_instr, load_data} = 0;
    repeat (4) @(negedge clk_sys);
    cmp(compat32_mode, 1);
    rst_n = 1;
    @(negedge clk_sys);
    cmp({tocop_order_tag, nullify_strobe, tocop_data_strobe}, 0);
    t_types;
    t_stall;
    t_busy;
    t_fifo;
    give_verdict;
  end
  initial
  begin
    #400000;
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule
bind cpd_dispatch cpd_dispatch_asserts u_chk (.*);
